// ### rtl/core_timing_pkg.sv
// package: register map, cycle counts, opcode classes and carrier types of the core timing block
package core_timing_pkg;

  // register offsets on the register port
  localparam logic [7:0] ADDR_STACK_TOP   = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_PAIR_LOW    = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_PAIR_HIGH   = 8'h83;
  localparam logic [7:0] ADDR_DATA_POINTER_PAIR_PAGE   = 8'h84;
  localparam logic [7:0] ADDR_POWER       = 8'h87;
  localparam logic [7:0] ADDR_TIMER_LOW   = 8'h8a;
  localparam logic [7:0] ADDR_TIMER_HIGH  = 8'h8b;
  localparam logic [7:0] ADDR_TIMER_CTL   = 8'h8e;
  localparam logic [7:0] ADDR_STATUS      = 8'h8f;
  localparam logic [7:0] ADDR_XDATA_WAIT  = 8'h9f;
  localparam logic [7:0] ADDR_CLK_DIV     = 8'hd7;

  // reset values
  localparam logic [7:0] RST_STACK_TOP    = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_PAIR         = 8'h00;
  localparam logic [7:0] RST_POWER        = 8'h00;
  localparam logic [7:0] RST_XDATA_WAIT   = 8'h00;
  localparam logic [7:0] RST_CLK_DIV      = 8'h03;
  localparam logic [7:0] RST_ZERO         = 8'h00;

  // field positions
  localparam int         CLK_DIV_LSB      = 0;
  localparam int         CLK_DIV_W        = 3;
  localparam int         TIMER_RUN_BIT    = 0;
  localparam int         TIMER_CLR_BIT    = 1;
  localparam int         STATUS_BUSY_BIT  = 0;
  localparam int         STATUS_XMOVE_BIT = 1;

  // machine cycles per instruction class
  localparam logic [8:0] CYC_ONE          = 9'h001;
  localparam logic [8:0] CYC_TWO          = 9'h002;
  localparam logic [8:0] CYC_THREE        = 9'h003;
  localparam logic [8:0] CYC_FOUR         = 9'h004;
  localparam logic [8:0] CYC_NINE         = 9'h009;
  localparam logic [8:0] CYC_XMOVE_BASE   = 9'h004;
  localparam logic [8:0] CYC_IRQ_CALL     = 9'h003;

  // opcode classes, ? marks a don't-care bit
  localparam logic [7:0] OP_ADD_REG       = 8'b0010_1???;
  localparam logic [7:0] OP_ADDC_REG      = 8'b0011_1???;
  localparam logic [7:0] OP_SUBB_REG      = 8'b1001_1???;
  localparam logic [7:0] OP_ADD_IND       = 8'b0010_011?;
  localparam logic [7:0] OP_ADDC_IND      = 8'b0011_011?;
  localparam logic [7:0] OP_SUBB_IND      = 8'b1001_011?;
  localparam logic [7:0] OP_ADD_DIR       = 8'h25;
  localparam logic [7:0] OP_ADD_IMM       = 8'h24;
  localparam logic [7:0] OP_ADDC_DIR      = 8'h35;
  localparam logic [7:0] OP_ADDC_IMM      = 8'h34;
  localparam logic [7:0] OP_SUBB_DIR      = 8'h95;
  localparam logic [7:0] OP_SUBB_IMM      = 8'h94;
  localparam logic [7:0] OP_INC_ACC       = 8'h04;
  localparam logic [7:0] OP_DEC_ACC       = 8'h14;
  localparam logic [7:0] OP_INC_REG       = 8'b0000_1???;
  localparam logic [7:0] OP_DEC_REG       = 8'b0001_1???;
  localparam logic [7:0] OP_INC_IND       = 8'b0000_011?;
  localparam logic [7:0] OP_DEC_IND       = 8'b0001_011?;
  localparam logic [7:0] OP_INC_DIR       = 8'h05;
  localparam logic [7:0] OP_DEC_DIR       = 8'h15;
  localparam logic [7:0] OP_INC_DATA_POINTER_PAIR      = 8'ha3;
  localparam logic [7:0] OP_MUL           = 8'ha4;
  localparam logic [7:0] OP_DIV           = 8'h84;
  localparam logic [7:0] OP_DEC_ADJ       = 8'hd4;
  localparam logic [7:0] OP_XMOVE_RD_PTR  = 8'he0;
  localparam logic [7:0] OP_XMOVE_RD_IND  = 8'b1110_001?;
  localparam logic [7:0] OP_XMOVE_WR_PTR  = 8'hf0;
  localparam logic [7:0] OP_XMOVE_WR_IND  = 8'b1111_001?;
  localparam logic [7:0] OP_LONG_CALL     = 8'h12;

  // one word from the on-chip program store
  typedef struct packed {
    logic [7:0] opcode;
    logic       from_irq;
  } fetch_word_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } exec_state_t;

endpackage

// ### rtl/instr_cycle_table.sv
// instruction decoder: machine cycles needed by each opcode
`timescale 1ns/10ps
module instr_cycle_table (
  // instruction
  input  wire logic [7:0] opcode,
  input  wire logic       from_irq,
  input  wire logic [7:0] wait_count,
  // result
  output logic [8:0]      cycles,
  output logic            xmove
);

  always_comb begin
    cycles = core_timing_pkg::CYC_ONE;
    xmove  = 1'b0;
    casez (opcode)
      core_timing_pkg::OP_ADD_REG,
      core_timing_pkg::OP_ADDC_REG,
      core_timing_pkg::OP_SUBB_REG: cycles = core_timing_pkg::CYC_ONE;
      core_timing_pkg::OP_ADD_IND,
      core_timing_pkg::OP_ADDC_IND,
      core_timing_pkg::OP_SUBB_IND: cycles = core_timing_pkg::CYC_TWO;
      core_timing_pkg::OP_ADD_DIR,
      core_timing_pkg::OP_ADD_IMM,
      core_timing_pkg::OP_ADDC_DIR,
      core_timing_pkg::OP_ADDC_IMM,
      core_timing_pkg::OP_SUBB_DIR: cycles = core_timing_pkg::CYC_TWO;
      core_timing_pkg::OP_SUBB_IMM: cycles = core_timing_pkg::CYC_ONE;
      core_timing_pkg::OP_INC_ACC,
      core_timing_pkg::OP_DEC_ACC,
      core_timing_pkg::OP_INC_REG,
      core_timing_pkg::OP_DEC_REG:  cycles = core_timing_pkg::CYC_ONE;
      core_timing_pkg::OP_INC_IND,
      core_timing_pkg::OP_DEC_IND:  cycles = core_timing_pkg::CYC_TWO;
      core_timing_pkg::OP_INC_DIR,
      core_timing_pkg::OP_DEC_DIR:  cycles = core_timing_pkg::CYC_TWO;
      core_timing_pkg::OP_INC_DATA_POINTER_PAIR: cycles = core_timing_pkg::CYC_THREE;
      core_timing_pkg::OP_MUL,
      core_timing_pkg::OP_DIV:      cycles = core_timing_pkg::CYC_NINE;
      core_timing_pkg::OP_DEC_ADJ:  cycles = core_timing_pkg::CYC_TWO;
      core_timing_pkg::OP_XMOVE_RD_PTR,
      core_timing_pkg::OP_XMOVE_RD_IND,
      core_timing_pkg::OP_XMOVE_WR_PTR,
      core_timing_pkg::OP_XMOVE_WR_IND: begin
        cycles = core_timing_pkg::CYC_XMOVE_BASE + {1'b0, wait_count};
        xmove  = 1'b1;
      end
      core_timing_pkg::OP_LONG_CALL: begin
        cycles = from_irq ? core_timing_pkg::CYC_IRQ_CALL : core_timing_pkg::CYC_FOUR;
      end
      default: cycles = core_timing_pkg::CYC_ONE;
    endcase
  end

endmodule // instr_cycle_table

// ### rtl/machine_cycle_timer.sv
// timer that counts machine cycles
`timescale 1ns/10ps
module machine_cycle_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // control
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        clear,
  // state
  output logic [15:0]      count_q
);

  logic [15:0] count_d;

  always_comb begin
    count_d = count_q;
    if (run && tick) begin
      count_d = count_q + 16'h0001;
    end
    if (clear) begin
      count_d = 16'h0000;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

endmodule // machine_cycle_timer

// ### rtl/single_cycle_core_timing.sv
// single-cycle core timing: machine cycle pacing, address latch strobe, wait states, registers
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module single_cycle_core_timing (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // on-chip program store
  input  wire logic                         fetch_valid,
  input  wire core_timing_pkg::fetch_word_t fetch_word,
  output logic                              fetch_ready_q,
  // register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic [7:0]                        reg_rdata_q,
  // timing outputs
  output logic                              ale_q,
  output logic                              instr_done_q,
  // external data memory
  output logic                              xdata_active_q,
  output logic [23:0]                       xdata_addr_q
);

  // period of one machine cycle in clk cycles, minus one
  function automatic logic [7:0] period_m1(input logic [2:0] div);
    logic [8:0] period;
    period    = 9'h002 << div;
    period_m1 = 8'(period - 9'h001);
  endfunction

  // a register write hit
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = wr && (addr == target);
  endfunction

  // machine cycle pacing
  logic [7:0]                   phase_q;
  logic [7:0]                   phase_d;
  logic [7:0]                   pm1_q;
  logic [7:0]                   pm1_d;
  logic                         wrap;

  // instruction sequencing
  core_timing_pkg::exec_state_t st_q;
  core_timing_pkg::exec_state_t st_d;
  logic [8:0]                   cyc_q;
  logic [8:0]                   cyc_d;
  logic [8:0]                   last_q;
  logic [8:0]                   last_d;
  logic [7:0]                   op_q;
  logic [7:0]                   op_d;
  logic                         xmove_q;
  logic                         xmove_d;
  logic                         accept;
  logic                         last_cyc;
  logic                         done_now;
  logic                         ready_d;
  logic                         ale_d;
  logic                         xact_d;
  logic [8:0]                   dec_cycles;
  logic                         dec_xmove;

  // software registers
  logic [7:0]                   stack_top_q;
  logic [7:0]                   stack_top_d;
  logic [7:0]                   data_pointer_pair_low_q;
  logic [7:0]                   data_pointer_pair_low_d;
  logic [7:0]                   data_pointer_pair_high_q;
  logic [7:0]                   data_pointer_pair_high_d;
  logic [7:0]                   data_pointer_pair_page_q;
  logic [7:0]                   data_pointer_pair_page_d;
  logic [7:0]                   power_q;
  logic [7:0]                   power_d;
  logic [7:0]                   xdata_wait_count_q;
  logic [7:0]                   xdata_wait_count_d;
  logic [7:0]                   core_clock_divider_ctl_q;
  logic [7:0]                   core_clock_divider_ctl_d;
  logic                         timer_run_q;
  logic                         timer_run_d;
  logic                         timer_clr;
  logic [15:0]                  timer_count;
  logic [15:0]                  data_pointer_pair_inc;
  logic [7:0]                   rdata_d;
  logic [23:0]                  xaddr_d;

  instr_cycle_table u_table (
    .opcode     (fetch_word.opcode),
    .from_irq   (fetch_word.from_irq),
    .wait_count (xdata_wait_count_q),
    .cycles     (dec_cycles),
    .xmove      (dec_xmove)
  );

  machine_cycle_timer u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .tick    (wrap),
    .run     (timer_run_q),
    .clear   (timer_clr),
    .count_q (timer_count)
  );

  assign wrap     = (phase_q == pm1_q);
  // the only code source is the on-chip store port; no external code path exists
  assign accept   = fetch_valid && fetch_ready_q;
  assign last_cyc = (cyc_q == last_q);
  assign done_now = (st_q == core_timing_pkg::ST_EXEC) && wrap && last_cyc;

  // core clock divider runs freely so the timer keeps counting while idle;
  // a new divider setting is taken only at a cycle boundary to avoid a torn cycle
  always_comb begin
    phase_d = wrap ? 8'h00 : 8'(phase_q + 8'h01);
    pm1_d   = wrap ? period_m1(core_clock_divider_ctl_q[core_timing_pkg::CLK_DIV_LSB +: core_timing_pkg::CLK_DIV_W])
                   : pm1_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= 8'h00;
      pm1_q   <= 8'h01;
    end else begin
      phase_q <= phase_d;
      pm1_q   <= pm1_d;
    end
  end

  // instruction sequencing: one counter per instruction paces strobe and completion
  always_comb begin
    st_d    = st_q;
    cyc_d   = cyc_q;
    last_d  = last_q;
    op_d    = op_q;
    xmove_d = xmove_q;
    if ((st_q == core_timing_pkg::ST_EXEC) && wrap) begin
      cyc_d = 9'(cyc_q + 9'h001);
      if (last_cyc) begin
        st_d    = core_timing_pkg::ST_IDLE;
        xmove_d = 1'b0;
      end
    end
    if (accept) begin
      st_d    = core_timing_pkg::ST_EXEC;
      cyc_d   = 9'h000;
      last_d  = 9'(dec_cycles - 9'h001);
      op_d    = fetch_word.opcode;
      xmove_d = dec_xmove;
    end
    // ready only in the final clk of a cycle that ends the instruction or of any idle cycle, so runs stay gapless
    ready_d = (phase_d == pm1_d) &&
              ((st_d == core_timing_pkg::ST_IDLE) || (cyc_d == last_d));
    // strobe high for the first half of the first cycle only
    ale_d   = (st_d == core_timing_pkg::ST_EXEC) && (cyc_d == 9'h000) &&
              (phase_d <= (pm1_d >> 1));
    xact_d  = (st_d == core_timing_pkg::ST_EXEC) && xmove_d && (cyc_d != 9'h000);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q           <= core_timing_pkg::ST_IDLE;
      cyc_q          <= 9'h000;
      last_q         <= 9'h000;
      op_q           <= 8'h00;
      xmove_q        <= 1'b0;
      fetch_ready_q  <= 1'b0;
      ale_q          <= 1'b0;
      instr_done_q   <= 1'b0;
      xdata_active_q <= 1'b0;
    end else begin
      st_q           <= st_d;
      cyc_q          <= cyc_d;
      last_q         <= last_d;
      op_q           <= op_d;
      xmove_q        <= xmove_d;
      fetch_ready_q  <= ready_d;
      ale_q          <= ale_d;
      instr_done_q   <= done_now;
      xdata_active_q <= xact_d;
    end
  end

  // software registers; a software write in the same cycle beats the pointer increment
  assign data_pointer_pair_inc  = 16'({data_pointer_pair_high_q, data_pointer_pair_low_q} + 16'h0001);
  assign timer_clr = wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_TIMER_CTL) &&
                     reg_wdata[core_timing_pkg::TIMER_CLR_BIT];

  always_comb begin
    stack_top_d              = stack_top_q;
    data_pointer_pair_low_d               = data_pointer_pair_low_q;
    data_pointer_pair_high_d              = data_pointer_pair_high_q;
    data_pointer_pair_page_d              = data_pointer_pair_page_q;
    power_d                  = power_q;
    xdata_wait_count_d       = xdata_wait_count_q;
    core_clock_divider_ctl_d = core_clock_divider_ctl_q;
    timer_run_d              = timer_run_q;
    if (done_now && (op_q == core_timing_pkg::OP_INC_DATA_POINTER_PAIR)) begin
      {data_pointer_pair_high_d, data_pointer_pair_low_d} = data_pointer_pair_inc;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_STACK_TOP)) begin
      stack_top_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_DATA_POINTER_PAIR_LOW)) begin
      data_pointer_pair_low_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_DATA_POINTER_PAIR_HIGH)) begin
      data_pointer_pair_high_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_DATA_POINTER_PAIR_PAGE)) begin
      data_pointer_pair_page_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_POWER)) begin
      power_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_XDATA_WAIT)) begin
      xdata_wait_count_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_CLK_DIV)) begin
      core_clock_divider_ctl_d = reg_wdata;
    end
    if (wr_hit(reg_wr, reg_addr, core_timing_pkg::ADDR_TIMER_CTL)) begin
      timer_run_d = reg_wdata[core_timing_pkg::TIMER_RUN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_top_q              <= core_timing_pkg::RST_STACK_TOP;
      data_pointer_pair_low_q               <= core_timing_pkg::RST_DATA_POINTER_PAIR;
      data_pointer_pair_high_q              <= core_timing_pkg::RST_DATA_POINTER_PAIR;
      data_pointer_pair_page_q              <= core_timing_pkg::RST_DATA_POINTER_PAIR;
      power_q                  <= core_timing_pkg::RST_POWER;
      xdata_wait_count_q       <= core_timing_pkg::RST_XDATA_WAIT;
      core_clock_divider_ctl_q <= core_timing_pkg::RST_CLK_DIV;
      timer_run_q              <= 1'b0;
    end else begin
      stack_top_q              <= stack_top_d;
      data_pointer_pair_low_q               <= data_pointer_pair_low_d;
      data_pointer_pair_high_q              <= data_pointer_pair_high_d;
      data_pointer_pair_page_q              <= data_pointer_pair_page_d;
      power_q                  <= power_d;
      xdata_wait_count_q       <= xdata_wait_count_d;
      core_clock_divider_ctl_q <= core_clock_divider_ctl_d;
      timer_run_q              <= timer_run_d;
    end
  end

  // read data stand one cycle after the strobe and read zero otherwise
  always_comb begin
    rdata_d = core_timing_pkg::RST_ZERO;
    xaddr_d = {data_pointer_pair_page_d, data_pointer_pair_high_d, data_pointer_pair_low_d};
    if (reg_rd) begin
      case (reg_addr)
        core_timing_pkg::ADDR_STACK_TOP:  rdata_d = stack_top_q;
        core_timing_pkg::ADDR_DATA_POINTER_PAIR_LOW:   rdata_d = data_pointer_pair_low_q;
        core_timing_pkg::ADDR_DATA_POINTER_PAIR_HIGH:  rdata_d = data_pointer_pair_high_q;
        core_timing_pkg::ADDR_DATA_POINTER_PAIR_PAGE:  rdata_d = data_pointer_pair_page_q;
        core_timing_pkg::ADDR_POWER:      rdata_d = power_q;
        core_timing_pkg::ADDR_TIMER_LOW:  rdata_d = timer_count[7:0];
        core_timing_pkg::ADDR_TIMER_HIGH: rdata_d = timer_count[15:8];
        core_timing_pkg::ADDR_TIMER_CTL:  rdata_d = {7'h00, timer_run_q};
        core_timing_pkg::ADDR_STATUS: begin
          rdata_d = core_timing_pkg::RST_ZERO;
          rdata_d[core_timing_pkg::STATUS_BUSY_BIT]  = (st_q == core_timing_pkg::ST_EXEC);
          rdata_d[core_timing_pkg::STATUS_XMOVE_BIT] = xmove_q;
        end
        core_timing_pkg::ADDR_XDATA_WAIT: rdata_d = xdata_wait_count_q;
        core_timing_pkg::ADDR_CLK_DIV:    rdata_d = core_clock_divider_ctl_q;
        default:                          rdata_d = core_timing_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q  <= 8'h00;
      xdata_addr_q <= 24'h000000;
    end else begin
      reg_rdata_q  <= rdata_d;
      xdata_addr_q <= xaddr_d;
    end
  end

endmodule // single_cycle_core_timing

// ### tb/core_timing_monitor.sv
// checker: port-level timing properties of the core timing block
`timescale 1ns/10ps
module core_timing_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // program store
  input wire logic        fetch_valid,
  input wire logic        fetch_ready_q,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata_q,
  // timing and external data
  input wire logic        ale_q,
  input wire logic        instr_done_q,
  input wire logic        xdata_active_q,
  input wire logic [23:0] xdata_addr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic take = fetch_valid && fetch_ready_q;
  property p_ale_start; take |=> ale_q; endproperty
  a_ale_start: assert property (p_ale_start) else $error("strobe missing after fetch");
  property p_ale_cause; $rose(ale_q) |-> $past(take); endproperty
  a_ale_cause: assert property (p_ale_cause) else $error("strobe rose without fetch");
  property p_xact_ale_low; xdata_active_q |-> !ale_q; endproperty
  a_xact_ale_low: assert property (p_xact_ale_low) else $error("strobe high in later cycle");
  property p_done_pulse; instr_done_q |=> !instr_done_q; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one clock");
  property p_ready_pulse; fetch_ready_q |=> !fetch_ready_q; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one clock");
  property p_xact_end; $fell(xdata_active_q) |-> instr_done_q; endproperty
  a_xact_end: assert property (p_xact_end) else $error("external move ended off completion");
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_wait_rb;
    reg_wr && reg_addr == 8'h9f ##1 reg_rd && reg_addr == 8'h9f |=> reg_rdata_q == $past(reg_wdata, 2);
  endproperty
  a_wait_rb: assert property (p_wait_rb) else $error("wait count readback wrong");
  property p_data_pointer_pair_low; reg_wr && reg_addr == 8'h82 |=> ##1 xdata_addr_q[7:0] == $past(reg_wdata, 2); endproperty
  a_data_pointer_pair_low: assert property (p_data_pointer_pair_low) else $error("pointer low not on address");
  c_fetch: cover property (take ##1 ale_q);
  c_xmove: cover property ($fell(xdata_active_q));
  c_read: cover property (reg_rd ##1 reg_rdata_q != 8'h00);
endmodule // core_timing_monitor
bind single_cycle_core_timing core_timing_monitor u_core_timing_monitor (.clk(clk), .rstn(rstn),
  .fetch_valid(fetch_valid), .fetch_ready_q(fetch_ready_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ale_q(ale_q), .instr_done_q(instr_done_q),
  .xdata_active_q(xdata_active_q), .xdata_addr_q(xdata_addr_q));

// ### tb/xram_model.sv
// external data memory model: times each external data move
`timescale 1ns/10ps
module xram_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // external data memory
  input  wire logic        xdata_active_q,
  input  wire logic [23:0] xdata_addr_q,
  // measurement
  output int               last_len,
  output logic [23:0]      last_addr
);
  int run_len;
  // a slow part relies only on the software wait count, so the access length is all it sees
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_len   <= 0;
      last_len  <= 0;
      last_addr <= 24'h000000;
    end else if (xdata_active_q) begin
      run_len   <= run_len + 1;
      last_addr <= xdata_addr_q;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len  <= 0;
    end
  end
endmodule // xram_model

// ### tb/tb.sv
// testbench: instruction cycle counts, strobe shape, wait states and registers
`timescale 1ns/10ps
module tb;
  logic                         clk = 1'b0;
  logic                         rstn = 1'b0;
  logic                         fetch_valid = 1'b0;
  core_timing_pkg::fetch_word_t fetch_word = '0;
  logic [7:0]                   reg_addr = 8'h00;
  logic [7:0]                   reg_wdata = 8'h00;
  logic                         reg_wr = 1'b0;
  logic                         reg_rd = 1'b0;
  logic [7:0]                   reg_rdata_q, rd, v, w;
  logic                         fetch_ready_q, ale_q, instr_done_q, xdata_active_q;
  logic [23:0]                  xdata_addr_q, last_addr;
  logic [7:0]                   vals [8];
  int                           last_len, dv, k, err_total = 0, n_compared = 0, seed = 83705;
  // opcode and expected machine cycles
  logic [11:0] tbl [24] = '{12'h281, 12'h381, 12'h981, 12'h262, 12'h362, 12'h962, 12'h252, 12'h242, 12'h352,
    12'h342, 12'h952, 12'h941, 12'h041, 12'h141, 12'h081, 12'h181, 12'h062, 12'h162, 12'h052, 12'h152,
    12'ha33, 12'ha49, 12'h849, 12'hd42};
  // address and reset value, 90 is unmapped
  logic [15:0] regs [8] = '{16'h8107, 16'h8200, 16'h8300, 16'h8400, 16'h8700, 16'h9f00, 16'hd703, 16'h9000};
  logic [7:0]  xops [4] = '{8'he0, 8'he2, 8'hf0, 8'hf3};
  always #2 clk = ~clk;
  single_cycle_core_timing u_single_cycle_core_timing (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready_q(fetch_ready_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ale_q(ale_q), .instr_done_q(instr_done_q),
    .xdata_active_q(xdata_active_q), .xdata_addr_q(xdata_addr_q));
  xram_model u_xram_model (.clk(clk), .rstn(rstn), .xdata_active_q(xdata_active_q),
    .xdata_addr_q(xdata_addr_q), .last_len(last_len), .last_addr(last_addr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata_q;
  endtask
  // counts clocks from the taking edge to the done pulse and the strobe-high clocks between
  task automatic run_op(input logic [7:0] op, input logic irq, input int n, input int p);
    int c, a;
    a = 0;
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_word  <= {op, irq};
    @(negedge clk);
    for (c = 0; c < 64 && fetch_ready_q !== 1'b1; c++) @(negedge clk);
    @(posedge clk);
    fetch_valid <= 1'b0;
    c = 0;
    do begin
      @(negedge clk);
      c++;
      a += (ale_q === 1'b1);
    end while (instr_done_q !== 1'b1 && c < 5000);
    check(c, n * p + 1);
    check(a, p / 2);
  endtask
  initial begin
    #200000;
    err_total++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (regs[i]) begin
      rdr(regs[i][15:8], rd);
      check(rd, regs[i][7:0]);
    end
    foreach (regs[i]) begin
      vals[i] = $random(seed);
      wr(regs[i][15:8], vals[i]);
      rdr(regs[i][15:8], rd);
      check(rd, (i == 7) ? 8'h00 : vals[i]);
    end
    check(xdata_addr_q, {vals[3], vals[2], vals[1]});
    wr(8'hd7, 8'h00);
    // a slow divider left by the random writes gives way only at its own cycle boundary
    repeat (260) @(posedge clk);
    wr(8'h9f, 8'h00);
    wr(8'h8e, 8'h03);
    rdr(8'h8a, rd);
    repeat (18) @(posedge clk);
    rdr(8'h8a, v);
    check(8'(v - rd), 8'd10);
    foreach (tbl[i]) run_op(tbl[i][11:4], 1'b0, tbl[i][3:0], 2);
    check(xdata_addr_q[15:0], 16'({vals[2], vals[1]} + 16'h0001));
    run_op(8'h12, 1'b1, 3, 2);
    run_op(8'h12, 1'b0, 4, 2);
    for (k = 0; k < 4; k++) begin
      w = (k == 0) ? 8'h00 : ($random(seed) & 8'h07);
      // write and read back with no gap between the strobes
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= 8'h9f;
      reg_wdata <= w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      check(reg_rdata_q, w);
      run_op(xops[k], 1'b0, 4 + w, 2);
      @(negedge clk);
      check(last_len, (3 + w) * 2);
    end
    check(last_addr, {vals[3], 16'({vals[2], vals[1]} + 16'h0001)});
    // back-to-back single-cycle ops: strobe and done each every second clock
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_word  <= {8'h28, 1'b0};
    repeat (8) @(negedge clk);
    dv = 0;
    k  = 0;
    repeat (16) begin
      @(negedge clk);
      dv += (ale_q === 1'b1);
      k  += (instr_done_q === 1'b1);
    end
    check(dv, 8);
    check(k, 8);
    rdr(8'h8f, rd);
    check(rd, 8'h01);
    @(posedge clk);
    fetch_valid <= 1'b0;
    // let the last op finish so its done pulse is not taken for the next one
    repeat (8) @(posedge clk);
    repeat (12) begin
      dv = {$random(seed)} % 3;
      k  = {$random(seed)} % 24;
      wr(8'hd7, 8'(dv));
      run_op(tbl[k][11:4], 1'b0, tbl[k][3:0], 2 << dv);
    end
    finish_test();
  end
endmodule // tb
